// ==== design/hdt_pkg.sv ====
package hdt_pkg;

  // apb geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [15:0] OFS_ACT_TOTAL = 16'h8330;
  localparam logic [15:0] OFS_BLANK_POS = 16'h8334;
  localparam logic [15:0] OFS_SYNC_POS = 16'h8338;
  localparam logic [15:0] OFS_STATUS = 16'h8350;

  // field layout shared by all three timing registers
  localparam int unsigned LO_MSB = 10;
  localparam int unsigned LO_LSB = 3;
  localparam int unsigned HI_MSB = 26;
  localparam int unsigned HI_LSB = 19;
  localparam int unsigned CHR_W = 8;

  // status register layout
  localparam int unsigned ST_CHR_LSB = 0;
  localparam int unsigned ST_BLANK_BIT = 8;
  localparam int unsigned ST_SYNC_BIT = 9;
  localparam int unsigned ST_ACT_BIT = 10;
  localparam int unsigned ST_LINE_LSB = 16;
  localparam int unsigned LINE_W = 11;

  // pixels per character clock
  localparam int unsigned PIX_W = 3;
  localparam logic [2:0] PIX_LAST = 3'h7;

  // reset values of the fields (hardware value is undefined, zero chosen)
  localparam logic [7:0] FIELD_RST = 8'h00;
  localparam logic [7:0] CHR_ZERO = 8'h00;
  localparam logic [7:0] CHR_ONE = 8'h01;
  localparam logic [10:0] LINE_ZERO = 11'h000;
  localparam logic [10:0] LINE_ONE = 11'h001;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ==== design/hdt_char_counter.sv ====
`timescale 1ns/10ps
`default_nettype none

module hdt_char_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] total_i,
  output logic [7:0] chr_o,
  output logic tick_o
);

  typedef struct packed {
    logic [2:0] pix;
    logic [7:0] chr;
    logic tick;
  } hdt_cnt_state_t;

  hdt_cnt_state_t s_q;
  hdt_cnt_state_t s_d;

  // eight pixel clocks make one character clock; chr wraps after total
  always_comb begin
    s_d = s_q;
    s_d.pix = s_q.pix + 3'h1;
    s_d.tick = 1'b0;
    if (s_q.pix == hdt_pkg::PIX_LAST) begin
      s_d.tick = 1'b1;
      if (s_q.chr >= total_i) begin
        s_d.chr = hdt_pkg::CHR_ZERO;
      end else begin
        s_d.chr = s_q.chr + hdt_pkg::CHR_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign chr_o = s_q.chr;
  assign tick_o = s_q.tick;

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick_o |=> !tick_o [*7] ##1 tick_o) else $error("char tick not every 8 clocks");

  a_counter_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    tick_o && ($past(chr_o) >= $past(total_i)) |-> chr_o == hdt_pkg::CHR_ZERO)
    else $error("char counter did not wrap at total");

endmodule // hdt_char_counter

`default_nettype wire

// ==== design/hdt_timing.sv ====
`timescale 1ns/10ps
`default_nettype none

module hdt_timing (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic crt_hblank,
  output logic crt_hsync,
  output logic panel_hblank,
  output logic panel_hsync,
  output logic disp_active,
  output logic line_advance
);

  typedef struct packed {
    logic [7:0] active_w;
    logic [7:0] total_w;
    logic [7:0] hblank_begin_pos;
    logic [7:0] hblank_stop_pos;
    logic [7:0] sync_begin_pos;
    logic [7:0] sync_stop_pos;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic hblank;
    logic hsync;
    logic active;
    logic adv;
    logic [10:0] line_cnt;
  } hdt_state_t;

  hdt_state_t s_q;
  hdt_state_t s_d;

  logic [7:0] chr;
  logic tick;
  logic setup_ph;
  logic wr_take;
  logic hit_act;
  logic hit_blank;
  logic hit_sync;
  logic hit_stat;
  logic hit_any;

  // character counter shared by both displays
  hdt_char_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .total_i(s_q.total_w),
    .chr_o(chr),
    .tick_o(tick)
  );

  // address decode on the full 16-bit offset
  assign hit_act = (paddr == hdt_pkg::OFS_ACT_TOTAL);
  assign hit_blank = (paddr == hdt_pkg::OFS_BLANK_POS);
  assign hit_sync = (paddr == hdt_pkg::OFS_SYNC_POS);
  assign hit_stat = (paddr == hdt_pkg::OFS_STATUS);
  assign hit_any = hit_act | hit_blank | hit_sync | hit_stat;

  // answer is prepared during setup so pready rises in the first access cycle
  assign setup_ph = psel & ~penable;
  // writes land only on the edge that samples pready high
  assign wr_take = psel & penable & pwrite & s_q.ready;

  // packs two position fields back into register form, pixel bits read zero
  function automatic logic [31:0] pack_pair(input logic [7:0] hi, input logic [7:0] lo);
    logic [31:0] w;
    w = hdt_pkg::WORD_ZERO;
    w[hdt_pkg::HI_MSB:hdt_pkg::HI_LSB] = hi;
    w[hdt_pkg::LO_MSB:hdt_pkg::LO_LSB] = lo;
    return w;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.ready = setup_ph;
    s_d.err = 1'b0;
    s_d.adv = 1'b0;

    // read data and error answer, latched at the end of setup
    if (setup_ph) begin
      s_d.err = ~hit_any;
      s_d.rdata = hdt_pkg::WORD_ZERO;
      if (!pwrite) begin
        if (hit_act) begin
          s_d.rdata = pack_pair(s_q.total_w, s_q.active_w);
        end else if (hit_blank) begin
          s_d.rdata = pack_pair(s_q.hblank_stop_pos, s_q.hblank_begin_pos);
        end else if (hit_sync) begin
          s_d.rdata = pack_pair(s_q.sync_stop_pos, s_q.sync_begin_pos);
        end else if (hit_stat) begin
          s_d.rdata[hdt_pkg::ST_CHR_LSB +: hdt_pkg::CHR_W] = chr;
          s_d.rdata[hdt_pkg::ST_BLANK_BIT] = s_q.hblank;
          s_d.rdata[hdt_pkg::ST_SYNC_BIT] = s_q.hsync;
          s_d.rdata[hdt_pkg::ST_ACT_BIT] = s_q.active;
          s_d.rdata[hdt_pkg::ST_LINE_LSB +: hdt_pkg::LINE_W] = s_q.line_cnt;
        end
      end
    end

    // only the character bits are kept; pixel and reserved bits drop here
    if (wr_take) begin
      if (hit_act) begin
        s_d.active_w = pwdata[hdt_pkg::LO_MSB:hdt_pkg::LO_LSB];
        s_d.total_w = pwdata[hdt_pkg::HI_MSB:hdt_pkg::HI_LSB];
      end
      if (hit_blank) begin
        s_d.hblank_begin_pos = pwdata[hdt_pkg::LO_MSB:hdt_pkg::LO_LSB];
        s_d.hblank_stop_pos = pwdata[hdt_pkg::HI_MSB:hdt_pkg::HI_LSB];
      end
      if (hit_sync) begin
        s_d.sync_begin_pos = pwdata[hdt_pkg::LO_MSB:hdt_pkg::LO_LSB];
        s_d.sync_stop_pos = pwdata[hdt_pkg::HI_MSB:hdt_pkg::HI_LSB];
      end
    end

    // compare on the cycle after the counter moves; outputs lag chr by one clock
    if (tick) begin
      s_d.active = (chr <= s_q.active_w);
      // begin wins when both positions match, so blank never sticks off
      if (chr == s_q.hblank_begin_pos) begin
        s_d.hblank = 1'b1;
      end else if (chr == s_q.hblank_stop_pos) begin
        s_d.hblank = 1'b0;
      end
      if (chr == s_q.sync_begin_pos) begin
        s_d.hsync = 1'b1;
      end else if (chr == s_q.sync_stop_pos) begin
        s_d.hsync = 1'b0;
      end
    end

    // vertical side steps on the rising sync edge, even with panel only
    if (s_d.hsync && !s_q.hsync) begin
      s_d.adv = 1'b1;
      s_d.line_cnt = s_q.line_cnt + hdt_pkg::LINE_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // one timing source drives both displays
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign crt_hblank = s_q.hblank;
  assign panel_hblank = s_q.hblank;
  assign crt_hsync = s_q.hsync;
  assign panel_hsync = s_q.hsync;
  assign disp_active = s_q.active;
  assign line_advance = s_q.adv;

  // apb answer: one access cycle, error only for unmapped places
  a_pready_one_wait: assert property (@(posedge pclk)
    disable iff (!presetn) psel && !penable
    |=> pready ##1 !pready)
    else $error("pready not a single access cycle");

  a_no_ready_idle: assert property (@(posedge pclk)
    disable iff (!presetn) !psel
    |=> !pready)
    else $error("pready raised without a transfer");

  a_err_with_ready: assert property (@(posedge pclk)
    disable iff (!presetn) pslverr
    |-> pready)
    else $error("pslverr outside the access cycle");

  a_err_unmapped: assert property (@(posedge pclk)
    disable iff (!presetn) psel && !penable && !hit_any
    |=> pslverr)
    else $error("unmapped address not refused");

  a_no_err_mapped: assert property (@(posedge pclk)
    disable iff (!presetn) psel && !penable && hit_any
    |=> !pslverr)
    else $error("mapped address refused");

  a_unmapped_reads_zero: assert property (@(posedge pclk)
    disable iff (!presetn) pready && pslverr && !pwrite
    |-> prdata == hdt_pkg::WORD_ZERO)
    else $error("unmapped read returned data");

  a_spare_bits_zero: assert property (@(posedge pclk)
    disable iff (!presetn) pready && !pwrite && (hit_act || hit_blank || hit_sync)
    |-> prdata[hdt_pkg::LO_LSB - 1:0] == '0
      && prdata[hdt_pkg::HI_LSB - 1:hdt_pkg::LO_MSB + 1] == '0
      && prdata[hdt_pkg::DATA_W - 1:hdt_pkg::HI_MSB + 1] == '0)
    else $error("ignored bits of a timing register read nonzero");

  // register fields: only character bits are kept, and only on a write
  a_active_taken: assert property (@(posedge pclk)
    disable iff (!presetn) wr_take && hit_act
    |=> s_q.active_w == $past(pwdata[hdt_pkg::LO_MSB:hdt_pkg::LO_LSB]))
    else $error("active width not taken from lower field");

  a_total_taken: assert property (@(posedge pclk)
    disable iff (!presetn) wr_take && hit_act
    |=> s_q.total_w == $past(pwdata[hdt_pkg::HI_MSB:hdt_pkg::HI_LSB]))
    else $error("line total not taken from upper field");

  a_low_bits_ignored: assert property (@(posedge pclk)
    disable iff (!presetn) wr_take && hit_blank
    |=> s_q.hblank_begin_pos == $past(pwdata[hdt_pkg::LO_MSB:hdt_pkg::LO_LSB])
      && s_q.hblank_stop_pos == $past(pwdata[hdt_pkg::HI_MSB:hdt_pkg::HI_LSB]))
    else $error("blank fields not taken from character bits");

  a_sync_fields: assert property (@(posedge pclk)
    disable iff (!presetn) wr_take && hit_sync
    |=> s_q.sync_begin_pos == $past(pwdata[hdt_pkg::LO_MSB:hdt_pkg::LO_LSB])
      && s_q.sync_stop_pos == $past(pwdata[hdt_pkg::HI_MSB:hdt_pkg::HI_LSB]))
    else $error("sync fields not taken from character bits");

  a_fields_hold: assert property (@(posedge pclk)
    disable iff (!presetn) !(wr_take && (hit_act || hit_blank || hit_sync))
    |=> $stable(s_q.active_w) && $stable(s_q.total_w)
      && $stable(s_q.hblank_begin_pos) && $stable(s_q.hblank_stop_pos)
      && $stable(s_q.sync_begin_pos) && $stable(s_q.sync_stop_pos))
    else $error("timing field changed without a write");

  // line timing: outputs move one clock after the character count
  a_blank_begins: assert property (@(posedge pclk)
    disable iff (!presetn) tick && chr == s_q.hblank_begin_pos
    |=> crt_hblank && panel_hblank)
    else $error("blank did not begin at begin position");

  a_blank_ends: assert property (@(posedge pclk)
    disable iff (!presetn) tick && chr == s_q.hblank_stop_pos && chr != s_q.hblank_begin_pos
    |=> !crt_hblank)
    else $error("blank did not end at stop position");

  a_sync_starts: assert property (@(posedge pclk)
    disable iff (!presetn) tick && chr == s_q.sync_begin_pos
    |=> crt_hsync && panel_hsync)
    else $error("sync did not start at begin position");

  a_sync_ends: assert property (@(posedge pclk)
    disable iff (!presetn) tick && chr == s_q.sync_stop_pos && chr != s_q.sync_begin_pos
    |=> !crt_hsync)
    else $error("sync did not end at stop position");

  a_blank_holds: assert property (@(posedge pclk)
    disable iff (!presetn) !tick
    |=> $stable(crt_hblank))
    else $error("blank moved between character ticks");

  a_sync_holds: assert property (@(posedge pclk)
    disable iff (!presetn) !tick
    |=> $stable(crt_hsync) && $stable(disp_active))
    else $error("sync or active moved between character ticks");

  a_active_width: assert property (@(posedge pclk)
    disable iff (!presetn) tick
    |=> disp_active == ($past(chr) <= $past(s_q.active_w)))
    else $error("active region disagrees with width");

  a_chr_steps: assert property (@(posedge pclk)
    disable iff (!presetn) tick && $past(chr) < $past(s_q.total_w)
    |-> chr == $past(chr) + hdt_pkg::CHR_ONE)
    else $error("char counter did not step by one");

  a_panel_matches: assert property (@(posedge pclk)
    disable iff (!presetn) panel_hblank == crt_hblank
      && panel_hsync == crt_hsync)
    else $error("panel timing differs from crt timing");

  a_line_advance: assert property (@(posedge pclk)
    disable iff (!presetn)
    line_advance == (crt_hsync && !$past(crt_hsync)))
    else $error("line advance not tied to sync rise");

  a_advance_single: assert property (@(posedge pclk)
    disable iff (!presetn) line_advance
    |=> !line_advance)
    else $error("line advance longer than one cycle");

  a_line_count_steps: assert property (@(posedge pclk)
    disable iff (!presetn) line_advance
    |-> s_q.line_cnt == $past(s_q.line_cnt) + hdt_pkg::LINE_ONE)
    else $error("line count did not step with line advance");

endmodule // hdt_timing

`default_nettype wire

// ==== test/hdt_display_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module hdt_display_model (
  input wire logic pclk,
  input wire logic hsync,
  input wire logic hblank,
  input wire logic active,
  input wire logic panel_hsync,
  input wire logic panel_hblank,
  input wire logic line_adv,
  output var int period,
  output var int sync_len,
  output var int blank_len,
  output var int act_len,
  output var int lines,
  output var int advs,
  output var int skew
);
  int cnt = 0;
  int s_run = 0;
  int b_run = 0;
  int a_run = 0;
  logic hs_q = 1'b0;
  logic hb_q = 1'b0;
  logic ac_q = 1'b0;

  initial begin
    {period, sync_len, blank_len, act_len, lines, advs, skew} = '0;
  end

  // a monitor only sees levels, so widths are taken at each falling edge
  always @(posedge pclk) begin
    hs_q <= hsync;
    hb_q <= hblank;
    ac_q <= active;
    cnt <= cnt + 1;
    s_run <= hsync ? s_run + 1 : 0;
    b_run <= hblank ? b_run + 1 : 0;
    a_run <= active ? a_run + 1 : 0;
    // new line starts on the sync rising edge
    if (hsync && !hs_q) begin
      period <= cnt;
      cnt <= 1;
      lines <= lines + 1;
    end
    if (!hsync && hs_q) sync_len <= s_run;
    if (!hblank && hb_q) blank_len <= b_run;
    if (!active && ac_q) act_len <= a_run;
    if (line_adv) advs <= advs + 1;
    // both displays must see the same timing
    if (panel_hsync !== hsync || panel_hblank !== hblank) skew <= skew + 1;
  end
endmodule // hdt_display_model

`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic crt_hblank, crt_hsync, panel_hblank, panel_hsync, disp_active, line_advance;
  int fail_count = 0;
  int n_compared = 0;
  int period, sync_len, blank_len, act_len, lines, advs, skew;

  hdt_timing i_hdt_timing (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crt_hblank(crt_hblank), .crt_hsync(crt_hsync),
    .panel_hblank(panel_hblank), .panel_hsync(panel_hsync), .disp_active(disp_active),
    .line_advance(line_advance));

  hdt_display_model i_hdt_display_model (.pclk(pclk), .hsync(crt_hsync), .hblank(crt_hblank),
    .active(disp_active), .panel_hsync(panel_hsync), .panel_hblank(panel_hblank),
    .line_adv(line_advance), .period(period), .sync_len(sync_len), .blank_len(blank_len),
    .act_len(act_len), .lines(lines), .advs(advs), .skew(skew));

  // 125 mhz pixel clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer; an edge passes after release so calls never collide
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      give_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // reset leaves every output low, the status word clear and the fields zero
  task automatic reset_state;
    check("reset sync", {crt_hsync, panel_hsync, line_advance}, 32'h0000_0000);
    check("reset blank", {crt_hblank, panel_hblank, disp_active, pslverr}, 32'h0000_0000);
    apb(1'b0, hdt_pkg::OFS_STATUS, 32'h0000_0000, e);
    check("status after reset", rd, 32'h0000_0000);
    check("status read error", e, 32'h0000_0000);
    // status is read only: a write is taken without error and changes nothing
    apb(1'b1, hdt_pkg::OFS_STATUS, 32'hFFFF_FFFF, e);
    check("status write error", e, 32'h0000_0000);
    apb(1'b0, hdt_pkg::OFS_ACT_TOTAL, 32'h0000_0000, e);
    check("fields after reset", rd, 32'h0000_0000);
  endtask

  // junk in every ignored and reserved bit
  function automatic logic [31:0] enc(input logic [7:0] hi, input logic [7:0] lo);
    return {5'h1F, hi, 3'h7, 5'h1F, lo, 3'h7};
  endfunction

  // only the character bits are stored, and unmapped places answer with an error
  task automatic reg_access;
    logic [15:0] ofs [3];
    ofs = '{hdt_pkg::OFS_ACT_TOTAL, hdt_pkg::OFS_BLANK_POS, hdt_pkg::OFS_SYNC_POS};
    foreach (ofs[i]) begin
      apb(1'b1, ofs[i], 32'hFFFF_FFFF, e);
      apb(1'b0, ofs[i], 32'h0000_0000, e);
      check("field bits", rd, 32'h07F8_07F8);
    end
    apb(1'b0, 16'h8340, 32'h0000_0000, e);
    check("unmapped error", e, 32'h0000_0001);
    check("unmapped read data", rd, 32'h0000_0000);
    apb(1'b1, 16'h8344, 32'h1234_5678, e);
    check("unmapped write error", e, 32'h0000_0001);
  endtask

  // program one line shape and measure what the display sees
  task automatic run_line(input logic [7:0] tot, act, bb, bs, sb, ss);
    apb(1'b1, hdt_pkg::OFS_ACT_TOTAL, enc(tot, act), e);
    apb(1'b1, hdt_pkg::OFS_BLANK_POS, enc(bs, bb), e);
    apb(1'b1, hdt_pkg::OFS_SYNC_POS, enc(ss, sb), e);
    repeat (40 * (tot + 1) + 20) @(posedge pclk);
    check("period", period, (tot + 1) * 8);
    check("active", act_len, (act + 1) * 8);
    check("blank", blank_len, ((bs - bb + tot + 1) % (tot + 1)) * 8);
    check("sync", sync_len, ((ss - sb + tot + 1) % (tot + 1)) * 8);
    check("panel skew", skew, 0);
    check("line advance", advs, lines);
  endtask

  // wide line: blanking spans five characters, same positions for both displays
  task automatic line_wide;
    run_line(8'h09, 8'h03, 8'h06, 8'h01, 8'h07, 8'h09);
  endtask

  // short line: sync wraps across the end of the line
  task automatic line_wrap;
    run_line(8'h04, 8'h00, 8'h02, 8'h01, 8'h04, 8'h00);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_state();
    reg_access();
    line_wide();
    line_wrap();
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
